// *** common/hdg_pkg.sv ***
// Shared constants, types and field functions of the hub descriptor generator
package hdg_pkg;

  // ==========================================================
  // Descriptor contents
  localparam int unsigned TOTAL_PORTS = 3; // Ports built into the hub
  localparam logic [7:0] EP_LEN = 8'h07; // Endpoint descriptor length
  localparam logic [7:0] EP_TYPE = 8'h05; // Endpoint descriptor type
  localparam logic [7:0] EP_ADDR = 8'h81; // Endpoint one, device to host
  localparam logic [7:0] EP_ATTR = 8'h03; // Interrupt, no sync, data
  localparam logic [15:0] EP_MPS = 16'h0001; // Max packet size
  localparam logic [7:0] EP_INTERVAL = 8'hff; // Slowest polling
  localparam logic [7:0] HUB_LEN = 8'h09; // Hub descriptor length
  localparam logic [7:0] HUB_TYPE = 8'h29; // Hub type, 1.1 and 2.0
  localparam logic [7:0] HUB_TYPE_OLD = 8'h00; // Hub type, 1.0
  localparam logic [1:0] TT_THINK_8FS = 2'b00; // Think time code
  localparam int unsigned PWR_GOOD_UNIT_MS = 2; // Unit of power-on time

  // ==========================================================
  // Register map, byte addresses
  localparam logic [3:0] ADDR_CFG = 4'h0; // Configuration load
  localparam logic [3:0] ADDR_STATUS = 4'h4; // Derived values, busy

  // Field positions in the configuration word
  localparam int unsigned CFG_MODE_POS = 0; // Power mode select
  localparam int unsigned CFG_PPWR_POS = 1; // Port power switching
  localparam int unsigned CFG_COMP_POS = 2; // Compound device
  localparam int unsigned CFG_OCS_POS = 3; // Over-current sensing, 2 bits
  localparam int unsigned CFG_DBP_POS = 8; // Disabled, bus powered, 3 bits
  localparam int unsigned CFG_DSP_POS = 12; // Disabled, self powered, 3 bits
  localparam int unsigned CFG_PON_POS = 16; // Power-on time, 8 bits

  // Field positions in the status word
  localparam int unsigned STS_PORTS_POS = 0; // Reported port count
  localparam int unsigned STS_CHAR_POS = 8; // Characteristics, low byte
  localparam int unsigned STS_BUSY_POS = 24; // Transfer in progress

  // Internal default: self powered, all ports on, 100 ms power-on
  localparam logic [31:0] CFG_RESET = 32'h0032_0009;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] power_on_time;
    logic [2:0] disabled_ports_self_powered;
    logic [2:0] disabled_ports_bus_powered;
    logic [1:0] overcurrent_sensing_setting;
    logic compound_device;
    logic port_power_switching_setting;
    logic power_mode_select;
  } hdg_cfg_type;

  typedef enum logic {
    HDG_KIND_EP = 1'b0,
    HDG_KIND_HUB = 1'b1
  } hdg_kind_type;

  // ==========================================================
  // Field functions
  function automatic hdg_cfg_type word_to_cfg(input logic [31:0] w);
    hdg_cfg_type c;
    c.power_mode_select = w[CFG_MODE_POS];
    c.port_power_switching_setting = w[CFG_PPWR_POS];
    c.compound_device = w[CFG_COMP_POS];
    c.overcurrent_sensing_setting = w[CFG_OCS_POS +: 2];
    c.disabled_ports_bus_powered = w[CFG_DBP_POS +: 3];
    c.disabled_ports_self_powered = w[CFG_DSP_POS +: 3];
    c.power_on_time = w[CFG_PON_POS +: 8];
    return c;
  endfunction

  function automatic logic [31:0] cfg_to_word(input hdg_cfg_type c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CFG_MODE_POS] = c.power_mode_select;
    w[CFG_PPWR_POS] = c.port_power_switching_setting;
    w[CFG_COMP_POS] = c.compound_device;
    w[CFG_OCS_POS +: 2] = c.overcurrent_sensing_setting;
    w[CFG_DBP_POS +: 3] = c.disabled_ports_bus_powered;
    w[CFG_DSP_POS +: 3] = c.disabled_ports_self_powered;
    w[CFG_PON_POS +: 8] = c.power_on_time;
    return w;
  endfunction

  // Ports left after removing those disabled in the active mode
  function automatic logic [7:0] nbr_ports(input hdg_cfg_type c);
    logic [2:0] dis;
    dis = c.power_mode_select ? c.disabled_ports_self_powered
                              : c.disabled_ports_bus_powered;
    return 8'(TOTAL_PORTS - $countones(dis));
  endfunction

  // Characteristics word; indicators and upper byte stay zero
  function automatic logic [15:0] hub_char(input hdg_cfg_type c);
    return {8'h00, 1'b0, TT_THINK_8FS, c.overcurrent_sensing_setting,
            c.compound_device, 1'b0, c.port_power_switching_setting};
  endfunction

endpackage

// *** dv/hdg_host_model.sv ***
// Host side model that takes the descriptor byte stream
`timescale 1ns/1ns
`default_nettype none

module hdg_host_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic slow,
  output logic tx_ready
);
  // ==========================================================
  // Capture store, cleared by the bench before each request
  logic [7:0] got[$]; // Bytes taken in order
  int lastat = -1; // Index of the byte that carried the last flag

  // Ready pattern: prompt, or every other cycle to stall the stream
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= slow ? !tx_ready : 1'b1;
    end
  end

  // Take a byte only on an edge with both sides agreeing
  always @(posedge mclk) begin
    if (arst_n && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (tx_last === 1'b1) begin
        lastat = got.size();
      end
      got.push_back(tx_data);
    end
  end
endmodule
`default_nettype wire

// *** dv/hdg_top_tb.sv ***
// Self-checking bench of the hub descriptor generator
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end

module hdg_top_tb;
  // ==========================================================
  // Signals
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic req_valid = 1'b0;
  hdg_pkg::hdg_kind_type req_kind = hdg_pkg::HDG_KIND_EP;
  logic [7:0] req_dtype = 8'h29;
  logic [15:0] req_len = 16'h0;
  logic tx_valid, tx_last, tx_ready, req_done, req_stall;
  logic [7:0] tx_data;
  logic slow = 1'b0; // Host stalls when set
  logic [31:0] cfgw = 32'h0032_0009; // Bench copy of the configuration
  logic [31:0] rd;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;

  hdg_top u_dut (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .req_valid(req_valid), .req_kind(req_kind), .req_dtype(req_dtype),
    .req_len(req_len), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .req_done(req_done),
    .req_stall(req_stall));

  hdg_host_model u_host (.mclk(mclk), .arst_n(arst_n), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .slow(slow), .tx_ready(tx_ready));

  // ==========================================================
  // Clock, reset and hang guard
  initial begin
    forever #25 mclk = !mclk;
  end

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One bus cycle held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Expected byte from the bench's own copy of the configuration
  function automatic logic [7:0] exp_b(input logic k, input int i);
    logic [2:0] d;
    logic [7:0] e[9];
    d = cfgw[0] ? cfgw[14:12] : cfgw[10:8];
    if (k) e = '{8'h09, 8'h29, 8'(3 - $countones(d)),
      {3'b000, cfgw[4:2], 1'b0, cfgw[1]}, 8'h00, cfgw[23:16], 8'h00,
      8'h00, 8'h00};
    else e = '{8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'hff, 8'h00,
      8'h00};
    return e[i];
  endfunction

  // Issue one request, wait for its end and judge every byte
  task automatic req(input logic k, input logic [7:0] dt,
                     input logic [15:0] len, input logic stall);
    int n;
    int i;
    n = stall ? 0 : (len < (k ? 9 : 7) ? int'(len) : (k ? 9 : 7));
    u_host.got.delete();
    u_host.lastat = -1;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_kind <= hdg_pkg::hdg_kind_type'(k);
    req_dtype <= dt;
    req_len <= len;
    @(posedge mclk);
    req_valid <= 1'b0;
    for (i = 0; i < 200 && req_done !== 1'b1 && req_stall !== 1'b1; i++)
      @(posedge mclk);
    `CHK(req_stall, stall)
    `CHK(req_done, !stall)
    `CHK(u_host.got.size(), n)
    for (i = 0; i < n && i < u_host.got.size(); i++)
      `CHK(u_host.got[i], exp_b(k, i))
    if (n > 0) `CHK(u_host.lastat, n - 1)
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    av(1'b0, 4'h0, 32'h0, 4'hf);
    `CHK(rd, 32'h0032_0009)
    av(1'b0, 4'h4, 32'h0, 4'hf);
    `CHK(rd, 32'h0000_0803)
    av(1'b0, 4'h8, 32'h0, 4'hf);
    `CHK(rd, 32'h0)
    av(1'b1, 4'h0, 32'hffff_ffff, 4'h1);
    av(1'b0, 4'h0, 32'h0, 4'hf);
    `CHK(rd, 32'h0032_001f)
    av(1'b1, 4'h0, 32'hffff_ffff, 4'hf);
    av(1'b0, 4'h0, 32'h0, 4'hf);
    `CHK(rd, 32'h00ff_771f)
    cfgw = 32'h0032_0009;
    av(1'b1, 4'h0, cfgw, 4'hf);
    $display("test regs done");
  endtask

  task automatic t_endpoint();
    req(1'b0, 8'h00, 16'd64, 1'b0);
    slow <= 1'b1;
    req(1'b0, 8'h00, 16'd7, 1'b0);
    slow <= 1'b0;
    $display("test endpoint done");
  endtask

  // Both accepted type values, one refused, stall then recovery
  task automatic t_hub_types();
    req(1'b1, 8'h29, 16'd9, 1'b0);
    req(1'b1, 8'h22, 16'd9, 1'b1);
    slow <= 1'b1;
    req(1'b1, 8'h00, 16'd255, 1'b0);
    slow <= 1'b0;
    $display("test hub types done");
  endtask

  // Configuration sweep across both power modes and all fields
  task automatic t_cfg_sweep();
    logic [31:0] c[6];
    c = '{32'h0000_0000, 32'h0064_0702, 32'h0010_1705, 32'h0080_5308,
          32'h0001_6011, 32'h00ff_001f};
    foreach (c[j]) begin
      cfgw = c[j];
      av(1'b1, 4'h0, cfgw, 4'hf);
      req(1'b1, 8'h29, 16'd9, 1'b0);
      req(1'b1, 8'h00, 16'd9, 1'b0);
    end
    $display("test config sweep done");
  endtask

  task automatic t_short();
    req(1'b0, 8'h00, 16'd3, 1'b0);
    req(1'b1, 8'h29, 16'd5, 1'b0);
    req(1'b1, 8'h29, 16'd0, 1'b0);
    req(1'b0, 8'h00, 16'd1, 1'b0);
    $display("test short done");
  endtask

  // Reset in mid-run drops a loaded setup back to the internal default
  task automatic t_reset();
    cfgw = 32'h0001_6011;
    av(1'b1, 4'h0, cfgw, 4'hf);
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK(avs_waitrequest, 1'b1)
    `CHK(tx_valid, 1'b0)
    arst_n <= 1'b1;
    cfgw = hdg_pkg::CFG_RESET;
    av(1'b0, 4'h0, 32'h0, 4'hf);
    `CHK(rd, hdg_pkg::CFG_RESET)
    req(1'b1, 8'h29, 16'd9, 1'b0);
    $display("test reset done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    t_endpoint();
    t_hub_types();
    t_cfg_sweep();
    t_short();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire

// *** src/hdg_cfg_regs.sv ***
// Configuration store and Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none

module hdg_cfg_regs #(
  parameter logic [31:0] CFG_DEFAULT = hdg_pkg::CFG_RESET
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic busy,
  output hdg_pkg::hdg_cfg_type cfg
);

  // ==========================================================
  // State
  typedef struct packed {
    hdg_pkg::hdg_cfg_type cfg; // Active configuration
    logic wait_r; // Waitrequest, high between answers
    logic [31:0] rdata; // Read answer
  } hdg_regs_type;

  hdg_regs_type s_reg;
  hdg_regs_type s_next;
  logic [31:0] mask; // Byte lanes as bit mask
  logic [31:0] status; // Live status word
  logic [15:0] chr; // Characteristics word of the active setup

  // ==========================================================
  // Next state: one wait cycle, then commit on the answering edge
  always_comb begin
    s_next = s_reg;
    mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    status = 32'h0000_0000;
    // Function results cannot be sliced directly, so go through a copy
    chr = hdg_pkg::hub_char(s_reg.cfg);
    status[hdg_pkg::STS_PORTS_POS +: 8] = hdg_pkg::nbr_ports(s_reg.cfg);
    status[hdg_pkg::STS_CHAR_POS +: 8] = chr[7:0];
    status[hdg_pkg::STS_BUSY_POS] = busy;
    s_next.wait_r = 1'b1;
    if ((avs_read || avs_write) && s_reg.wait_r) begin
      // First edge of a request: prepare answer
      s_next.wait_r = 1'b0;
      unique case (avs_address)
        hdg_pkg::ADDR_CFG: s_next.rdata = hdg_pkg::cfg_to_word(s_reg.cfg);
        hdg_pkg::ADDR_STATUS: s_next.rdata = status;
        default: s_next.rdata = 32'h0000_0000; // Unmapped reads zero
      endcase
    end else if (avs_write && !s_reg.wait_r) begin
      // Serial load replaces defaults, lane by lane
      if (avs_address == hdg_pkg::ADDR_CFG) begin // RULE_15
        s_next.cfg = hdg_pkg::word_to_cfg(
          (hdg_pkg::cfg_to_word(s_reg.cfg) & ~mask) | (avs_writedata & mask));
      end
    end
  end

  // ==========================================================
  // Registers; reset loads the internal default
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg.cfg <= hdg_pkg::word_to_cfg(CFG_DEFAULT); // RULE_15
      s_reg.wait_r <= 1'b1;
      s_reg.rdata <= 32'h0000_0000;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata = s_reg.rdata;
  assign avs_waitrequest = s_reg.wait_r;
  assign cfg = s_reg.cfg;

endmodule

`default_nettype wire

// *** src/hdg_desc_rom.sv ***
// Byte image of the endpoint and hub descriptors
`timescale 1ns/1ns
`default_nettype none

module hdg_desc_rom (
  input wire hdg_pkg::hdg_kind_type kind,
  input wire logic [3:0] idx,
  input wire hdg_pkg::hdg_cfg_type cfg,
  output logic [7:0] data
);

  logic [15:0] chr; // Characteristics word

  // ==========================================================
  // Lookup; multi-byte fields go low byte first
  always_comb begin
    chr = hdg_pkg::hub_char(cfg); // RULE_10 RULE_11 RULE_12 RULE_13
    data = 8'h00;
    if (kind == hdg_pkg::HDG_KIND_EP) begin
      unique case (idx)
        4'h0: data = hdg_pkg::EP_LEN; // RULE_01
        4'h1: data = hdg_pkg::EP_TYPE; // RULE_01
        4'h2: data = hdg_pkg::EP_ADDR; // RULE_02
        4'h3: data = hdg_pkg::EP_ATTR; // RULE_03
        4'h4: data = hdg_pkg::EP_MPS[7:0]; // RULE_04 RULE_17
        4'h5: data = hdg_pkg::EP_MPS[15:8]; // RULE_04 RULE_17
        4'h6: data = hdg_pkg::EP_INTERVAL; // RULE_05
        default: data = 8'h00; // Beyond the end
      endcase
    end else begin
      unique case (idx)
        4'h0: data = hdg_pkg::HUB_LEN; // RULE_07
        4'h1: data = hdg_pkg::HUB_TYPE; // RULE_07
        4'h2: data = hdg_pkg::nbr_ports(cfg); // RULE_08 RULE_09 RULE_16
        4'h3: data = chr[7:0]; // RULE_17
        4'h4: data = chr[15:8]; // RULE_17
        4'h5: data = cfg.power_on_time; // RULE_14
        default: data = 8'h00; // Bytes six to eight and beyond read zero
      endcase
    end
  end

endmodule

`default_nettype wire

// *** src/hdg_top.sv ***
// Top of the hub descriptor generator: request handling and byte stream
`timescale 1ns/1ns
`default_nettype none

// How it works
// [RULE_01] Endpoint descriptor: seven bytes, 07h then 05h
// [RULE_02] Endpoint address byte reads 81h
// [RULE_03] Endpoint attributes byte reads 03h, interrupt
// [RULE_04] Endpoint max packet size is 0001h
// [RULE_05] Endpoint polling interval byte reads FFh
// [RULE_06] Hub request accepted for type 29h or 00h
// [RULE_07] Hub descriptor starts 09h, 29h, any speed
// [RULE_08] Port count is three minus disabled ports
// [RULE_09] Mode picks bus or self disabled field
// [RULE_10] Characteristics bits 1:0 follow port power setting
// [RULE_11] Bit 2 compound, bits 4:3 over-current sensing
// [RULE_12] Bits 6:5 zero, think time 8 FS
// [RULE_13] Bit 7 and upper byte read zero
// [RULE_14] Power-on byte reports configured time unchanged
// [RULE_15] Fields come from loaded configuration, not constants
// [RULE_16] Mode bit zero bus powered, one self
// [RULE_17] Multi-byte fields sent low byte first
// [RULE_18] Short request returns only leading bytes
module hdg_top #(
  parameter logic [31:0] CFG_DEFAULT = hdg_pkg::CFG_RESET
) (
  input wire logic mclk,
  input wire logic arst_n,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Descriptor request from the control engine
  input wire logic req_valid,
  input wire hdg_pkg::hdg_kind_type req_kind,
  input wire logic [7:0] req_dtype,
  input wire logic [15:0] req_len,
  // Byte stream of the data stage
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  // Request outcome
  output logic req_done,
  output logic req_stall
);

  // ==========================================================
  // Types and state
  typedef enum logic [1:0] {
    HDG_ST_IDLE = 2'b01, // Waiting for a request
    HDG_ST_SEND = 2'b10 // Streaming bytes
  } hdg_state_type;

  typedef struct packed {
    hdg_state_type st; // Sequencer state
    hdg_pkg::hdg_kind_type kind; // Descriptor being sent
    logic [3:0] idx; // Offset of byte on tx_data
    logic [3:0] total; // Bytes to send in this stage
    logic tx_valid; // Byte on offer
    logic [7:0] tx_data; // Byte value
    logic tx_last; // Final byte of stage
    logic done; // Stage finished, one cycle
    logic stall; // Request refused, one cycle
  } hdg_top_type;

  hdg_top_type s_reg;
  hdg_top_type s_next;

  hdg_pkg::hdg_cfg_type cfg; // Active configuration
  hdg_pkg::hdg_kind_type rom_kind; // Descriptor to look up
  logic [3:0] rom_idx; // Offset to look up
  logic [7:0] rom_data; // Looked-up byte
  logic [3:0] desc_len; // Full length of requested descriptor
  logic [3:0] clip; // Bytes actually sent
  logic type_ok; // Hub type value accepted
  logic busy; // Stage in progress

  // ==========================================================
  // Configuration store and register slave
  hdg_cfg_regs #(
    .CFG_DEFAULT(CFG_DEFAULT)
  ) u_regs (
    .mclk(mclk),
    .arst_n(arst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .busy(busy),
    .cfg(cfg)
  );

  // ==========================================================
  // Descriptor image lookup
  hdg_desc_rom u_rom (
    .kind(rom_kind),
    .idx(rom_idx),
    .cfg(cfg),
    .data(rom_data)
  );

  // ==========================================================
  // Lookup address: first byte when idle, next byte when sending
  always_comb begin
    busy = (s_reg.st == HDG_ST_SEND);
    rom_kind = busy ? s_reg.kind : req_kind;
    rom_idx = busy ? 4'(s_reg.idx + 4'h1) : 4'h0;
  end

  // ==========================================================
  // Request checks and length clipping
  always_comb begin
    // Both hub type values give the same descriptor
    type_ok = (req_dtype == hdg_pkg::HUB_TYPE) ||
              (req_dtype == hdg_pkg::HUB_TYPE_OLD); // RULE_06
    desc_len = (req_kind == hdg_pkg::HDG_KIND_EP) ?
               hdg_pkg::EP_LEN[3:0] : hdg_pkg::HUB_LEN[3:0];
    // Host asking for less gets the leading bytes only
    if (req_len < 16'(desc_len)) begin // RULE_18
      clip = req_len[3:0];
    end else begin
      clip = desc_len;
    end
  end

  // ==========================================================
  // Sequencer next state
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.stall = 1'b0;
    unique case (s_reg.st)
      HDG_ST_IDLE: begin
        if (req_valid) begin
          if (req_kind == hdg_pkg::HDG_KIND_HUB && !type_ok) begin
            // Unknown class type: refuse
            s_next.stall = 1'b1; // RULE_06
          end else if (clip == 4'h0) begin
            // Zero length: nothing to send
            s_next.done = 1'b1; // RULE_18
          end else begin
            // Offer first byte at once
            s_next.st = HDG_ST_SEND;
            s_next.kind = req_kind;
            s_next.idx = 4'h0;
            s_next.total = clip;
            s_next.tx_valid = 1'b1;
            s_next.tx_data = rom_data;
            s_next.tx_last = (clip == 4'h1); // RULE_18
          end
        end
      end
      HDG_ST_SEND: begin
        if (tx_ready) begin
          if (s_reg.tx_last) begin
            // Stage ends after the clipped count
            s_next.st = HDG_ST_IDLE;
            s_next.tx_valid = 1'b0;
            s_next.tx_last = 1'b0;
            s_next.tx_data = 8'h00;
            s_next.done = 1'b1; // RULE_18
          end else begin
            // Advance in offset order, low byte first
            s_next.idx = 4'(s_reg.idx + 4'h1); // RULE_17
            s_next.tx_data = rom_data;
            s_next.tx_last = (4'(s_reg.idx + 4'h2) == s_reg.total);
          end
        end
      end
    endcase
  end

  // ==========================================================
  // Sequencer registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '{st: HDG_ST_IDLE, kind: hdg_pkg::HDG_KIND_EP,
                 default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flip-flops
  assign tx_valid = s_reg.tx_valid;
  assign tx_data = s_reg.tx_data;
  assign tx_last = s_reg.tx_last;
  assign req_done = s_reg.done;
  assign req_stall = s_reg.stall;

  // ==========================================================
  // Assertions and covers
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // Byte-on-offer helpers
  logic ep_on; // Endpoint byte offered
  logic hub_on; // Hub byte offered
  logic [15:0] chr_exp; // Expected characteristics
  logic [2:0] dis_exp; // Disabled set of active mode
  always_comb begin
    ep_on = s_reg.tx_valid && s_reg.kind == hdg_pkg::HDG_KIND_EP;
    hub_on = s_reg.tx_valid && s_reg.kind == hdg_pkg::HDG_KIND_HUB;
    chr_exp = {9'h000, 2'b00, cfg.overcurrent_sensing_setting,
               cfg.compound_device, 1'b0,
               cfg.port_power_switching_setting};
    dis_exp = cfg.power_mode_select ? cfg.disabled_ports_self_powered
                                    : cfg.disabled_ports_bus_powered;
  end

  a_ep_head: assert property ( // RULE_01
    ep_on && s_reg.idx < 4'h2 |->
      s_reg.tx_data == (s_reg.idx == 4'h0 ? 8'h07 : 8'h05))
    else $error("endpoint header byte wrong");

  a_ep_addr_attr: assert property ( // RULE_02 RULE_03
    ep_on && (s_reg.idx == 4'h2 || s_reg.idx == 4'h3) |->
      s_reg.tx_data == (s_reg.idx == 4'h2 ? 8'h81 : 8'h03))
    else $error("endpoint address or attributes wrong");

  // Offset four may stand for several cycles while the host stalls,
  // so judge the pair at the edge that takes the low byte
  a_ep_mps_order: assert property ( // RULE_04 RULE_17
    ep_on && s_reg.idx == 4'h4 && tx_ready && !s_reg.tx_last |->
      s_reg.tx_data == 8'h01 ##1
      s_reg.idx == 4'h5 && s_reg.tx_data == 8'h00)
    else $error("max packet size bytes wrong");

  a_ep_interval: assert property ( // RULE_05
    ep_on && s_reg.idx == 4'h6 |-> s_reg.tx_data == 8'hff && s_reg.tx_last)
    else $error("endpoint interval wrong");

  // Zero length is left out: with an accepted type it ends with done instead of bytes
  a_hub_type: assert property ( // RULE_06
    s_reg.st == HDG_ST_IDLE && req_valid &&
    req_kind == hdg_pkg::HDG_KIND_HUB && req_len != 16'h0000 |=>
      s_reg.stall == !(($past(req_dtype) == 8'h29) ||
                       ($past(req_dtype) == 8'h00)))
    else $error("hub type acceptance wrong");

  a_hub_head: assert property ( // RULE_07
    hub_on && s_reg.idx < 4'h2 |->
      s_reg.tx_data == (s_reg.idx == 4'h0 ? 8'h09 : 8'h29))
    else $error("hub header byte wrong");

  a_hub_ports: assert property ( // RULE_08 RULE_09 RULE_16
    hub_on && s_reg.idx == 4'h2 |->
      s_reg.tx_data == 8'(3 - $countones(dis_exp)))
    else $error("port count wrong");

  a_hub_char: assert property ( // RULE_10 RULE_11 RULE_12 RULE_13
    hub_on && (s_reg.idx == 4'h3 || s_reg.idx == 4'h4) |->
      s_reg.tx_data == (s_reg.idx == 4'h3 ? chr_exp[7:0] : 8'h00))
    else $error("hub characteristics wrong");

  a_pwr_good: assert property ( // RULE_14 RULE_15
    hub_on && s_reg.idx == 4'h5 |-> s_reg.tx_data == cfg.power_on_time)
    else $error("power-on time wrong");

  a_len_trunc: assert property ( // RULE_18
    s_reg.tx_valid && s_reg.tx_last |->
      s_reg.idx == 4'(s_reg.total - 4'h1) ##0
      s_reg.total <= (s_reg.kind == hdg_pkg::HDG_KIND_EP ? 4'h7 : 4'h9))
    else $error("stage length wrong");

  a_done_after_last: assert property ( // RULE_18
    s_reg.tx_valid && s_reg.tx_last && tx_ready |=>
      s_reg.done && !s_reg.tx_valid)
    else $error("stage did not end");

  c_ep_full: cover property (
    ep_on && s_reg.idx == 4'h6 && tx_ready);
  c_hub_full: cover property (
    hub_on && s_reg.idx == 4'h8 && tx_ready);
  c_short: cover property (
    hub_on && s_reg.tx_last && s_reg.total == 4'h2);
  c_stall: cover property (s_reg.stall);

endmodule

`default_nettype wire
